// file: rtl/csmc_clock_source_monitor_control.sv
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps

// Functional notes
// - Gate bit one enables peripheral clock
// - Gate bit zero stops peripheral clock
// - Gate bits 21,20,16,9,8,4,0 implemented
// - Ring/crystal oscillator two-bit control fields
// - Status bits valid only while watching
// - Crystal watch detects presence, not stability
// - Policy bit, when set, disables ring fallback
// - Watch enables: main resets one, crystal zero
// - Bits 6 and 2 enable fail interrupts
// - Bit 5 main fail pending, write-one-clear
// - Bit 1 crystal fail pending, write-one-clear
// - Bit 4 reports main clock present
// - Bit 0 reports crystal running
module csmc_clock_source_monitor_control (
  input  wire logic                   core_clk_i,    // System clock
  input  wire logic                   reset_i,       // Sync reset, high
  input  wire logic                   hsel_i,        // AHB select
  input  wire logic [31:0]            haddr_i,       // AHB address
  input  wire logic [1:0]             htrans_i,      // AHB transfer type
  input  wire logic                   hwrite_i,      // AHB write
  input  wire logic [2:0]             hsize_i,       // AHB size
  input  wire logic [31:0]            hwdata_i,      // AHB write data
  input  wire logic                   hready_i,      // AHB bus ready
  output logic                        hreadyout_o,   // AHB slave ready
  output logic                        hresp_o,       // AHB response
  output logic [31:0]                 hrdata_o,      // AHB read data
  input  wire logic                   main_alive_i,  // Main clock seen
  input  wire logic                   xtal_alive_i,  // Crystal toggles
  input  wire logic                   no_fallback_i, // Fallback strap
  output logic [31:0]                 periph_clk_en_o, // Clock gates
  output csmc_pkg::csmc_clk_ctl_s     clk_ctl_o,     // Source controls
  output logic                        irq_o          // Fail interrupt
);
  import csmc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]              gate;       // Peripheral clock gates
    csmc_clk_ctl_s            ctl;        // Oscillator and select
    logic                     mwatch;     // Main watch enable
    logic                     xwatch;     // Crystal watch enable
    logic                     mie;        // Main fail irq enable
    logic                     xie;        // Crystal fail irq enable
    logic                     mpend;      // Main fail pending
    logic                     xpend;      // Crystal fail pending
    logic                     mpres;      // Main clock present
    logic                     xrun;       // Crystal running
    logic                     policy;     // Fallback disabled
    logic [2:0]               sync1;      // Sync first stage
    logic [2:0]               sync2;      // Sync second stage
    logic                     wr_pend;    // Write data phase due
    logic [CSMC_NUM_REGS-1:0] wr_hit;     // Latched write target
    logic [31:0]              rdata;      // Read data
    logic                     irq;        // Interrupt line
    logic                     ready;      // Slave ready
  } csmc_state_s;

  csmc_state_s st_r;    // Registered state
  csmc_state_s st_nxt;  // Next state

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One-hot hit vector for an address
  function automatic logic [CSMC_NUM_REGS-1:0] reg_hit(
    input logic [31:0] addr
  );
    logic [CSMC_NUM_REGS-1:0] hit;
    hit = '0;
    hit[CSMC_HIT_GATE]   = (addr == CSMC_ADDR_GATE);
    hit[CSMC_HIT_OSC]    = (addr == CSMC_ADDR_OSC);
    hit[CSMC_HIT_SEL]    = (addr == CSMC_ADDR_SEL);
    hit[CSMC_HIT_MON]    = (addr == CSMC_ADDR_MON);
    hit[CSMC_HIT_IRQ_ST] = (addr == CSMC_ADDR_IRQ_ST);
    hit[CSMC_HIT_IRQ_CL] = (addr == CSMC_ADDR_IRQ_CL);
    hit[CSMC_HIT_IRQ_EN] = (addr == CSMC_ADDR_IRQ_EN);
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  // Word seen by a read of the hit register
  function automatic logic [31:0] reg_read(
    input logic [CSMC_NUM_REGS-1:0] hit,
    input csmc_state_s              s
  );
    logic [31:0] d;
    d = CSMC_RD_ZERO;
    if (hit[CSMC_HIT_GATE]) begin
      d = s.gate & CSMC_GATE_MASK;
    end
    if (hit[CSMC_HIT_OSC]) begin
      d[CSMC_OSC_RING_LO +: 2] = s.ctl.ring_osc_control;
      d[CSMC_OSC_XTAL_LO +: 2] = s.ctl.crystal_osc_control;
    end
    if (hit[CSMC_HIT_SEL]) begin
      d[CSMC_SEL_PLLIN] = s.ctl.pll_input_select;
      d[CSMC_SEL_MAIN_LO +: 2] = s.ctl.main_clock_source_select;
    end
    if (hit[CSMC_HIT_MON]) begin
      d[CSMC_MON_POLICY] = s.policy;
      d[CSMC_MON_MWATCH] = s.mwatch;
      d[CSMC_MON_MIE]    = s.mie;
      d[CSMC_MON_MPEND]  = s.mpend;
      d[CSMC_MON_MPRES]  = s.mpres;
      d[CSMC_MON_XWATCH] = s.xwatch;
      d[CSMC_MON_XIE]    = s.xie;
      d[CSMC_MON_XPEND]  = s.xpend;
      d[CSMC_MON_XRUN]   = s.xrun;
    end
    if (hit[CSMC_HIT_IRQ_ST]) begin
      d[CSMC_IRQ_MAIN] = s.mpend;
      d[CSMC_IRQ_XTAL] = s.xpend;
    end
    if (hit[CSMC_HIT_IRQ_EN]) begin
      d[CSMC_IRQ_MAIN] = s.mie;
      d[CSMC_IRQ_XTAL] = s.xie;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic acc;  // Transfer taken this cycle

  // Bus, register writes, monitors and interrupt
  always_comb begin
    st_nxt = st_r;
    acc = hsel_i & htrans_i[CSMC_HTRANS_ACT] & hready_i;

    // Two-stage synchronisers for outside levels
    st_nxt.sync1 = {no_fallback_i, xtal_alive_i, main_alive_i};
    st_nxt.sync2 = st_r.sync1;
    // Policy is read-only, follows its strap
    st_nxt.policy = st_r.sync2[2];

    // Write data phase
    if (st_r.wr_pend) begin
      if (st_r.wr_hit[CSMC_HIT_GATE]) begin
        st_nxt.gate = hwdata_i & CSMC_GATE_MASK;
      end
      if (st_r.wr_hit[CSMC_HIT_OSC]) begin
        st_nxt.ctl.ring_osc_control =
          hwdata_i[CSMC_OSC_RING_LO +: 2];
        st_nxt.ctl.crystal_osc_control =
          hwdata_i[CSMC_OSC_XTAL_LO +: 2];
      end
      if (st_r.wr_hit[CSMC_HIT_SEL]) begin
        st_nxt.ctl.pll_input_select = hwdata_i[CSMC_SEL_PLLIN];
        st_nxt.ctl.main_clock_source_select =
          hwdata_i[CSMC_SEL_MAIN_LO +: 2];
      end
      if (st_r.wr_hit[CSMC_HIT_MON]) begin
        st_nxt.mwatch = hwdata_i[CSMC_MON_MWATCH];
        st_nxt.xwatch = hwdata_i[CSMC_MON_XWATCH];
        st_nxt.mie = hwdata_i[CSMC_MON_MIE];
        st_nxt.xie = hwdata_i[CSMC_MON_XIE];
        if (hwdata_i[CSMC_MON_MPEND]) begin
          st_nxt.mpend = 1'b0;
        end
        if (hwdata_i[CSMC_MON_XPEND]) begin
          st_nxt.xpend = 1'b0;
        end
      end
      // Clear register, same layout as status
      if (st_r.wr_hit[CSMC_HIT_IRQ_CL]) begin
        if (hwdata_i[CSMC_IRQ_MAIN]) begin
          st_nxt.mpend = 1'b0;
        end
        if (hwdata_i[CSMC_IRQ_XTAL]) begin
          st_nxt.xpend = 1'b0;
        end
      end
      // Enable register aliases the monitor enables
      if (st_r.wr_hit[CSMC_HIT_IRQ_EN]) begin
        st_nxt.mie = hwdata_i[CSMC_IRQ_MAIN];
        st_nxt.xie = hwdata_i[CSMC_IRQ_XTAL];
      end
    end

    // Main clock monitor; set wins over a clear
    // status updates only while watching
    if (st_r.mwatch) begin
      st_nxt.mpres = st_r.sync2[0];
      if (!st_r.sync2[0]) begin
        st_nxt.mpend = 1'b1;
        if (!st_r.policy) begin
          st_nxt.ctl.main_clock_source_select = CSMC_MAIN_RING;
          if (!st_nxt.ctl.ring_osc_control[1]) begin
            st_nxt.ctl.ring_osc_control = CSMC_OSC_ON;
          end
        end
      end
    end

    // Crystal monitor: presence of toggling only
    // presence detect, no stability check
    if (st_r.xwatch) begin
      st_nxt.xrun = st_r.sync2[1];
      if (!st_r.sync2[1]) begin
        st_nxt.xpend = 1'b1;
      end
    end

    st_nxt.irq = (st_nxt.mpend & st_nxt.mie) |
                 (st_nxt.xpend & st_nxt.xie);

    // Address phase; zero wait states
    st_nxt.ready   = 1'b1;
    st_nxt.wr_pend = acc & hwrite_i;
    st_nxt.wr_hit  = reg_hit(haddr_i);
    if (acc && !hwrite_i) begin
      // Read sees the effect of a write in flight
      st_nxt.rdata = reg_read(reg_hit(haddr_i), st_nxt);
    end else begin
      st_nxt.rdata = CSMC_RD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset to documented defaults
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.gate <= CSMC_GATE_RST;
      st_r.ctl.ring_osc_control <= CSMC_OSC_RING_RST;
      st_r.ctl.crystal_osc_control <= CSMC_OSC_XTAL_RST;
      st_r.ctl.main_clock_source_select <= CSMC_MAIN_RST;
      st_r.mwatch <= 1'b1;
      st_r.mpres <= 1'b1;
      // Alive levels at reset, so no false fail after release
      st_r.sync1 <= CSMC_SYNC_RST;
      st_r.sync2 <= CSMC_SYNC_RST;
      st_r.ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from flip-flops, except hresp_o tied low
  // ----------------------------------------------------------------
  assign hreadyout_o     = st_r.ready;
  assign hresp_o         = 1'b0;
  assign hrdata_o        = st_r.rdata;
  assign periph_clk_en_o = st_r.gate;
  assign clk_ctl_o       = st_r.ctl;
  assign irq_o           = st_r.irq;

endmodule

// file: rtl/csmc_pkg.sv
package csmc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] CSMC_ADDR_GATE   = 32'h4000_0034;
  localparam logic [31:0] CSMC_ADDR_OSC    = 32'h4000_0040;
  localparam logic [31:0] CSMC_ADDR_SEL    = 32'h4000_0044;
  localparam logic [31:0] CSMC_ADDR_MON    = 32'h4000_0048;
  localparam logic [31:0] CSMC_ADDR_IRQ_ST = 32'h4000_0070;
  localparam logic [31:0] CSMC_ADDR_IRQ_CL = 32'h4000_0074;
  localparam logic [31:0] CSMC_ADDR_IRQ_EN = 32'h4000_0078;

  // ----------------------------------------------------------------
  // Decode indices (one-hot hit vector)
  // ----------------------------------------------------------------
  localparam int CSMC_HIT_GATE   = 0;
  localparam int CSMC_HIT_OSC    = 1;
  localparam int CSMC_HIT_SEL    = 2;
  localparam int CSMC_HIT_MON    = 3;
  localparam int CSMC_HIT_IRQ_ST = 4;
  localparam int CSMC_HIT_IRQ_CL = 5;
  localparam int CSMC_HIT_IRQ_EN = 6;
  localparam int CSMC_NUM_REGS   = 7;

  // ----------------------------------------------------------------
  // Peripheral clock gate layout
  // ----------------------------------------------------------------
  localparam int CSMC_GATE_CONV1 = 21;
  localparam int CSMC_GATE_CONV0 = 20;
  localparam int CSMC_GATE_MPWM  = 16;
  localparam int CSMC_GATE_SER1  = 9;
  localparam int CSMC_GATE_SER0  = 8;
  localparam int CSMC_GATE_TWI   = 4;
  localparam int CSMC_GATE_SSP   = 0;
  localparam logic [31:0] CSMC_GATE_MASK = 32'h0031_0311;
  localparam logic [31:0] CSMC_GATE_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Oscillator and select fields
  // ----------------------------------------------------------------
  localparam int CSMC_OSC_RING_LO = 4;
  localparam int CSMC_OSC_XTAL_LO = 0;
  localparam logic [1:0] CSMC_OSC_ON     = 2'h2;
  localparam logic [1:0] CSMC_OSC_RING_RST = 2'h2;
  localparam logic [1:0] CSMC_OSC_XTAL_RST = 2'h0;
  localparam int CSMC_SEL_PLLIN = 2;
  localparam int CSMC_SEL_MAIN_LO = 0;
  localparam logic [1:0] CSMC_MAIN_RING = 2'h0;
  localparam logic [1:0] CSMC_MAIN_RST  = 2'h0;
  // Synchroniser reset: main and crystal idle as alive, strap low
  localparam logic [2:0] CSMC_SYNC_RST  = 3'h3;

  // ----------------------------------------------------------------
  // Monitor register layout
  // ----------------------------------------------------------------
  localparam int CSMC_MON_POLICY  = 15;
  localparam int CSMC_MON_MWATCH  = 7;
  localparam int CSMC_MON_MIE     = 6;
  localparam int CSMC_MON_MPEND   = 5;
  localparam int CSMC_MON_MPRES   = 4;
  localparam int CSMC_MON_XWATCH  = 3;
  localparam int CSMC_MON_XIE     = 2;
  localparam int CSMC_MON_XPEND   = 1;
  localparam int CSMC_MON_XRUN    = 0;

  // ----------------------------------------------------------------
  // Interrupt status / clear / enable layout
  // ----------------------------------------------------------------
  localparam int CSMC_IRQ_MAIN = 0;
  localparam int CSMC_IRQ_XTAL = 1;

  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam int CSMC_HTRANS_ACT = 1;
  localparam logic [31:0] CSMC_RD_ZERO = 32'h0000_0000;

  // Clock control outputs
  typedef struct packed {
    logic [1:0] ring_osc_control;
    logic [1:0] crystal_osc_control;
    logic       pll_input_select;
    logic [1:0] main_clock_source_select;
  } csmc_clk_ctl_s;

endpackage

// file: testbench/csmc_chk_sva.sv
`timescale 1ns/10ps
module csmc_chk
  import csmc_pkg::*;
(
  input wire logic          core_clk_i,      // Clock
  input wire logic          reset_i,         // Sync reset
  input wire logic          hsel_i,          // Select
  input wire logic [31:0]   haddr_i,         // Address
  input wire logic [1:0]    htrans_i,        // Transfer type
  input wire logic          hwrite_i,        // Write
  input wire logic [31:0]   hwdata_i,        // Write data
  input wire logic          hready_i,        // Bus ready
  input wire logic          hreadyout_o,     // Slave ready
  input wire logic          hresp_o,         // Response
  input wire logic [31:0]   hrdata_o,        // Read data
  input wire logic          main_alive_i,    // Main clock seen
  input wire logic          xtal_alive_i,    // Crystal toggles
  input wire logic          no_fallback_i,   // Policy strap
  input wire logic [31:0]   periph_clk_en_o, // Clock gates
  input csmc_clk_ctl_s      clk_ctl_o,       // Source controls
  input wire logic          irq_o            // Interrupt
);
  logic        wr_q;   // Write data phase
  logic        rd_q;   // Read data phase
  logic        seen_q; // Some source has failed
  logic [31:0] adr_q;  // Address of data phase
  // ----------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      seen_q <= 1'b0;
      adr_q  <= 32'h0;
    end else begin
      wr_q   <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
      rd_q   <= hsel_i && htrans_i[1] && hready_i && !hwrite_i;
      seen_q <= seen_q || !main_alive_i || !xtal_alive_i;
      adr_q  <= haddr_i;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_gate_bits_only: assert property (
    (periph_clk_en_o & ~CSMC_GATE_MASK) == 32'h0)
    else $error("gate bit outside the gate map");
  a_gate_write_lands: assert property (wr_q && adr_q == CSMC_ADDR_GATE
    |=> periph_clk_en_o == ($past(hwdata_i) & CSMC_GATE_MASK))
    else $error("gate write not applied");
  a_crystal_code_write: assert property (wr_q && adr_q == CSMC_ADDR_OSC
    |=> clk_ctl_o.crystal_osc_control == $past(hwdata_i[1:0]))
    else $error("crystal code write not applied");
  a_pll_sel_write: assert property (wr_q && adr_q == CSMC_ADDR_SEL
    |=> clk_ctl_o.pll_input_select == $past(hwdata_i[2]))
    else $error("pll input select write not applied");
  a_bus_always_okay: assert property (hreadyout_o && !hresp_o)
    else $error("slave not ready or not okay");
  a_read_idle_zero: assert property (!rd_q |-> hrdata_o == 32'h0)
    else $error("read data outside read data phase");
  a_ring_fallback: assert property ((!main_alive_i && !no_fallback_i)[*4]
    |-> clk_ctl_o.main_clock_source_select == 2'h0
        && clk_ctl_o.ring_osc_control[1])
    else $error("no fallback to ring oscillator");
  a_irq_has_cause: assert property (irq_o |-> seen_q)
    else $error("interrupt without any failure");
  a_reset_controls: assert property ($fell(reset_i)
    |-> clk_ctl_o == 7'h40 && periph_clk_en_o == 32'h0)
    else $error("control outputs not at reset value");
  c_gate_write: cover property (wr_q && adr_q == CSMC_ADDR_GATE);
  c_irq_rise: cover property ($rose(irq_o));
  c_main_loss: cover property (!main_alive_i [*4]);
endmodule
bind csmc_clock_source_monitor_control csmc_chk csmc_chk_inst (
  .core_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o,
  .main_alive_i, .xtal_alive_i, .no_fallback_i, .periph_clk_en_o,
  .clk_ctl_o, .irq_o);

// file: testbench/test_clock_source_monitor_control.sv
`timescale 1ns/10ps
module test_clock_source_monitor_control;
  import csmc_pkg::*;
  logic          core_clk_i, reset_i, hsel_i, hwrite_i; // Bus controls
  logic [31:0]   haddr_i, hwdata_i;                     // Bus address, data
  logic [1:0]    htrans_i;                              // Transfer type
  logic [2:0]    hsize_i;                               // Transfer size
  logic          main_alive_i, xtal_alive_i;            // Monitor inputs
  logic          no_fallback_i;                         // Policy strap
  wire           hready_i, hreadyout_o, hresp_o, irq_o; // Replies
  wire [31:0]    hrdata_o, periph_clk_en_o;             // Data, gates
  csmc_clk_ctl_s clk_ctl_o;                             // Source controls
  int            n_fail, cmp_count;                     // Tallies
  int            gb [7] = '{21, 20, 16, 9, 8, 4, 0};   // Gate bits
  assign hready_i = hreadyout_o;
  csmc_clock_source_monitor_control csmc_clock_source_monitor_control_inst (
    .core_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o,
    .main_alive_i, .xtal_alive_i, .no_fallback_i, .periph_clk_en_o,
    .clk_ctl_o, .irq_o);
  task automatic test_done;
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Wait for ready under a bound
  task automatic ahb_wait;
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hready_i !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_fail++;
      test_done;
    end
  endtask
  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    hwrite_i <= 1'b1;
    htrans_i <= 2'h2;
    ahb_wait;
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    hwdata_i <= d;
    ahb_wait;
    @(posedge core_clk_i);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    hwrite_i <= 1'b0;
    htrans_i <= 2'h2;
    ahb_wait;
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    ahb_wait;
    chk(hrdata_o, exp);
  endtask
  task automatic t_gate;
    ahb_wr(CSMC_ADDR_GATE, 32'hFFFF_FFFF);
    rd_chk(CSMC_ADDR_GATE, CSMC_GATE_MASK);
    foreach (gb[i]) begin
      ahb_wr(CSMC_ADDR_GATE, 32'h1 << gb[i]);
      chk(periph_clk_en_o, 32'h1 << gb[i]);
      ahb_wr(CSMC_ADDR_GATE, 32'h0);
      chk(periph_clk_en_o, 32'h0);
    end
  endtask
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      ahb_wr(CSMC_ADDR_OSC, 32'((i % 4) * 17));
      rd_chk(CSMC_ADDR_OSC, 32'((i % 4) * 17));
      chk({30'h0, clk_ctl_o.ring_osc_control}, 32'(i % 4));
      ahb_wr(CSMC_ADDR_OSC, 32'h22); // both running first
      ahb_wr(CSMC_ADDR_SEL, 32'(i));
      rd_chk(CSMC_ADDR_SEL, 32'(i));
      chk({29'h0, clk_ctl_o[2:0]}, 32'(i));
    end
    ahb_wr(32'h4000_0050, 32'hFFFF_FFFF);
    rd_chk(32'h4000_0050, 32'h0);
    rd_chk(CSMC_ADDR_IRQ_CL, 32'h0);
  endtask
  task automatic t_crystal;
    xtal_alive_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    rd_chk(CSMC_ADDR_MON, 32'h0000_0090);
    ahb_wr(CSMC_ADDR_MON, 32'h0000_008C);
    repeat (5) @(posedge core_clk_i);
    rd_chk(CSMC_ADDR_MON, 32'h0000_009E);
    chk({31'h0, irq_o}, 32'h1);
    rd_chk(CSMC_ADDR_IRQ_ST, 32'h2);
    ahb_wr(CSMC_ADDR_IRQ_EN, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    ahb_wr(CSMC_ADDR_IRQ_EN, 32'h2);
    chk({31'h0, irq_o}, 32'h1);
    xtal_alive_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    ahb_wr(CSMC_ADDR_IRQ_CL, 32'h2);
    rd_chk(CSMC_ADDR_MON, 32'h0000_009D);
    chk({31'h0, irq_o}, 32'h0);
    ahb_wr(CSMC_ADDR_MON, 32'h0000_0080);
  endtask
  task automatic t_main;
    ahb_wr(CSMC_ADDR_OSC, 32'h22); // both on while select moves
    ahb_wr(CSMC_ADDR_SEL, 32'h3);
    ahb_wr(CSMC_ADDR_OSC, 32'h2);
    ahb_wr(CSMC_ADDR_MON, 32'h0000_00C0);
    main_alive_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk({30'h0, clk_ctl_o.main_clock_source_select}, 32'h0);
    chk({30'h0, clk_ctl_o.ring_osc_control}, 32'h2);
    chk({31'h0, irq_o}, 32'h1);
    rd_chk(CSMC_ADDR_MON, 32'h0000_00E1);
    main_alive_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    ahb_wr(CSMC_ADDR_MON, 32'h0000_00E0);
    rd_chk(CSMC_ADDR_MON, 32'h0000_00D1);
    chk({31'h0, irq_o}, 32'h0);
    no_fallback_i <= 1'b1;
    ahb_wr(CSMC_ADDR_SEL, 32'h3);
    main_alive_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk({30'h0, clk_ctl_o.main_clock_source_select}, 32'h3);
    rd_chk(CSMC_ADDR_MON, 32'h0000_80E1);
    main_alive_i <= 1'b1;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    #400000;
    n_fail++;
    test_done;
  end
  initial begin
    {reset_i, hsel_i, hwrite_i, htrans_i} = 5'h10;
    {haddr_i, hwdata_i, hsize_i} = {64'h0, 3'h2};
    {main_alive_i, xtal_alive_i, no_fallback_i} = 3'h6;
    n_fail = 0;
    cmp_count = 0;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd_chk(CSMC_ADDR_MON, 32'h0000_0090);
    rd_chk(CSMC_ADDR_OSC, 32'h0000_0020);
    t_gate;
    t_codes;
    t_crystal;
    t_main;
    test_done;
  end
endmodule
